// *** isab_pkg.sv ***
package isab_pkg;
    localparam logic [15:0] PORT_RTC_ADDR = 16'h0070;
    localparam logic [15:0] PORT_RTC_DATA = 16'h0071;
    localparam logic [15:0] PORT_KBD_A = 16'h0060;
    localparam logic [15:0] PORT_KBD_B = 16'h0064;
    localparam logic [23:0] ROM_BASE = 24'h0F_0000;
    localparam logic [23:0] ONE_MEG = 24'h10_0000;
    localparam logic [1:0] PCI_DIV_LAST = 2'h1;
    localparam logic [3:0] CMD_WAIT = 4'h4;
    localparam logic [3:0] EXT8_WAIT = 4'h8;
    localparam logic [1:0] HOLD_HOST = 2'h2;
    localparam logic [2:0] DACK_IDLE = 3'h4;
    typedef enum logic [2:0] {
        ISAB_IDLE = 3'b000,
        ISAB_ADDR = 3'b001,
        ISAB_CMD = 3'b011,
        ISAB_END = 3'b010,
        ISAB_REFH = 3'b110,
        ISAB_SLV = 3'b111
    } isab_state_e;
    typedef enum logic [1:0] {
        ISAB_MEMRD = 2'h0,
        ISAB_MEMWR = 2'h1,
        ISAB_IORD = 2'h2,
        ISAB_IOWR = 2'h3
    } isab_kind_e;
    typedef struct packed {
        logic valid;
        logic dma;
        logic last;
        logic [1:0] chan;
        isab_kind_e kind;
        logic [23:0] addr;
        logic word;
    } isab_req_s;
    typedef struct packed {
        logic memr_n;
        logic memw_n;
        logic ior_n;
        logic iow_n;
        logic smemr_n;
        logic smemw_n;
        logic bhe_n;
        logic ref_n;
    } isab_cmd_s;
endpackage

// *** isab_port.sv ***
module isab_port
    import isab_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pci_bus_clk,
    input wire logic osc_ref,
    input wire logic clk_src_osc,
    input isab_req_s req,
    input wire logic refresh_req,
    input wire logic host_clk_tick,
    input wire logic chk_enable,
    input wire logic master_n,
    input wire logic [23:17] la_in,
    input wire logic [19:0] sa_in,
    input isab_cmd_s cmd_in,
    input wire logic zws_n,
    input wire logic iochrdy_in,
    input wire logic iochck_n,
    input wire logic mcs16_n,
    input wire logic slv_ready,
    input wire logic [3:0] irq_muxed_in,
    input wire logic [1:0] dma_req_muxed_in,
    output logic expansion_clk,
    output logic expansion_clk_double,
    output logic osc_ref_out,
    output logic [23:17] la_out,
    output logic la_oe,
    output logic [19:0] sa_out,
    output logic sa_oe,
    output isab_cmd_s cmd_out,
    output logic cmd_oe,
    output logic ale,
    output logic aen,
    output logic iochrdy_out,
    output logic iochrdy_oe,
    output logic host_bus_hold,
    output logic nmi,
    output logic busy,
    output logic done,
    output logic word_ok,
    output logic slv_hit,
    output logic [7:0] irq_demux,
    output logic [3:0] dma_req,
    output logic [2:0] dma_ack_encoded_out,
    output logic tc,
    output logic xcvr_oe_n,
    output logic clock_chip_addr_strobe,
    output logic rom_clockchip_sel_n,
    output logic keyboard_sel_n,
    output logic clock_chip_rw_n,
    output logic clock_chip_dstrobe_n,
    output logic gp_latch_sel_n
);
    isab_state_e state;
    isab_req_s cur;
    logic is_ref, src_osc, pci_q, osc_q, x2;
    logic [1:0] pdiv;
    logic [3:0] wcnt;
    logic [1:0] hcnt;
    logic master_on;

    function automatic logic io_is(input isab_req_s r,
                                   input logic [15:0] p);
        io_is = r.kind[1] && (r.addr[15:0] == p);
    endfunction

    assign master_on = ~master_n;

    // clock source latched only when idle
    always_ff @(posedge clk) begin
        if (rst)
            src_osc <= 1'b0;
        else if (state == ISAB_IDLE)
            src_osc <= clk_src_osc;
    end

    // clock generation from sampled sources
    always_ff @(posedge clk) begin
        if (rst) begin
            pci_q <= 1'b0;
            osc_q <= 1'b0;
            pdiv <= 2'h0;
            x2 <= 1'b0;
            expansion_clk <= 1'b0;
            expansion_clk_double <= 1'b0;
            osc_ref_out <= 1'b0;
        end else begin
            pci_q <= pci_bus_clk;
            osc_q <= osc_ref;
            osc_ref_out <= osc_ref;
            if (src_osc) begin
                if (osc_ref && !osc_q) begin
                    expansion_clk <= ~expansion_clk;
                    expansion_clk_double <= 1'b1;
                end else if (!osc_ref && osc_q) begin
                    expansion_clk_double <= 1'b0;
                end
            end else if (pci_bus_clk && !pci_q) begin
                pdiv <= pdiv + 2'h1;
                x2 <= ~x2;
                expansion_clk_double <= x2;
                if (pdiv == PCI_DIV_LAST || pdiv == 2'h3)
                    expansion_clk <= ~expansion_clk;
            end
        end
    end

    // strobe-phase demux of irq and dma requests
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_demux <= 8'h00;
            dma_req <= 4'h0;
        end else begin
            if (expansion_clk) begin
                irq_demux[3:0] <= irq_muxed_in;
                dma_req[1:0] <= dma_req_muxed_in;
            end else begin
                irq_demux[6:4] <= irq_muxed_in[2:0];
                irq_demux[7] <= ~irq_muxed_in[3];
                dma_req[3:2] <= dma_req_muxed_in;
            end
        end
    end

    // cycle sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ISAB_IDLE;
            cur <= '0;
            is_ref <= 1'b0;
            wcnt <= 4'h0;
            hcnt <= 2'h0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state)
                ISAB_IDLE: begin
                    if (master_on && cmd_in.ref_n == 1'b0) begin
                        is_ref <= 1'b1;
                        hcnt <= 2'h0;
                        state <= ISAB_REFH;
                    end else if (master_on) begin
                        state <= ISAB_SLV;
                        wcnt <= 4'h0;
                    end else if (refresh_req) begin
                        is_ref <= 1'b1;
                        hcnt <= 2'h0;
                        state <= ISAB_REFH;
                    end else if (req.valid) begin
                        cur <= req;
                        is_ref <= 1'b0;
                        state <= ISAB_ADDR;
                    end
                end
                ISAB_REFH: begin
                    if (host_clk_tick)
                        hcnt <= hcnt + 2'h1;
                    if (host_clk_tick && hcnt == HOLD_HOST - 2'h1) begin
                        state <= ISAB_CMD;
                        wcnt <= 4'h0;
                    end
                end
                ISAB_ADDR: begin
                    wcnt <= 4'h0;
                    state <= ISAB_CMD;
                end
                ISAB_CMD: begin
                    if (wcnt != 4'hf)
                        wcnt <= wcnt + 4'h1;
                    if (!zws_n && !is_ref)
                        state <= ISAB_END;
                    else if (wcnt >= CMD_WAIT && iochrdy_in)
                        state <= ISAB_END;
                end
                ISAB_END: begin
                    done <= 1'b1;
                    cur.valid <= 1'b0;
                    is_ref <= 1'b0;
                    state <= ISAB_IDLE;
                end
                ISAB_SLV: begin
                    if (wcnt != 4'hf)
                        wcnt <= wcnt + 4'h1;
                    if (master_n)
                        state <= ISAB_IDLE;
                end
                default: state <= ISAB_IDLE;
            endcase
        end
    end

    // pin drive and direction
    always_ff @(posedge clk) begin
        if (rst) begin
            ale <= 1'b0;
            aen <= 1'b0;
            la_out <= '0;
            sa_out <= '0;
            la_oe <= 1'b0;
            sa_oe <= 1'b1;
            cmd_oe <= 1'b1;
            cmd_out <= '1;
            host_bus_hold <= 1'b0;
            tc <= 1'b0;
            dma_ack_encoded_out <= DACK_IDLE;
            busy <= 1'b0;
            word_ok <= 1'b0;
        end else begin
            busy <= state != ISAB_IDLE;
            la_oe <= !master_on && state != ISAB_IDLE;
            sa_oe <= !master_on;
            cmd_oe <= !master_on;
            ale <= master_on || is_ref || (cur.valid && cur.dma) ||
                   state == ISAB_ADDR;
            aen <= cur.valid && cur.dma && state != ISAB_IDLE;
            host_bus_hold <= state == ISAB_REFH;
            if (state == ISAB_ADDR) begin
                la_out <= cur.addr[23:17];
                sa_out <= cur.addr[19:0];
            end
            cmd_out <= '1;
            if (state == ISAB_CMD && is_ref) begin
                cmd_out.memr_n <= 1'b0;
                cmd_out.smemr_n <= 1'b0;
                cmd_out.ref_n <= 1'b0;
            end else if (state == ISAB_CMD) begin
                cmd_out.bhe_n <= ~cur.word;
                cmd_out.memr_n <= cur.kind != ISAB_MEMRD;
                cmd_out.memw_n <= cur.kind != ISAB_MEMWR;
                cmd_out.ior_n <= cur.kind != ISAB_IORD;
                cmd_out.iow_n <= cur.kind != ISAB_IOWR;
                cmd_out.smemr_n <= !(cur.kind == ISAB_MEMRD &&
                                     cur.addr < ONE_MEG);
                cmd_out.smemw_n <= !(cur.kind == ISAB_MEMWR &&
                                     cur.addr < ONE_MEG);
            end
            word_ok <= state == ISAB_CMD && !is_ref && !cur.kind[1] &&
                       !mcs16_n;
            if (state == ISAB_CMD && cur.dma) begin
                dma_ack_encoded_out <= {1'b0, cur.chan};
                tc <= cur.last;
            end else begin
                dma_ack_encoded_out <= DACK_IDLE;
                tc <= 1'b0;
            end
        end
    end

    // slave side towards bus masters, nmi, x-bus decode
    always_ff @(posedge clk) begin
        if (rst) begin
            iochrdy_out <= 1'b1;
            iochrdy_oe <= 1'b0;
            slv_hit <= 1'b0;
            nmi <= 1'b0;
            xcvr_oe_n <= 1'b1;
            clock_chip_addr_strobe <= 1'b0;
            rom_clockchip_sel_n <= 1'b1;
            keyboard_sel_n <= 1'b1;
            clock_chip_rw_n <= 1'b1;
            clock_chip_dstrobe_n <= 1'b1;
            gp_latch_sel_n <= 1'b1;
        end else begin
            slv_hit <= state == ISAB_SLV && (!cmd_in.ior_n ||
                       !cmd_in.iow_n || !cmd_in.memr_n || !cmd_in.memw_n);
            iochrdy_oe <= state == ISAB_SLV;
            // internal access stretched as 8-bit io, no iocs16
            iochrdy_out <= slv_ready && wcnt >= EXT8_WAIT;
            nmi <= !iochck_n && chk_enable;
            xcvr_oe_n <= !(state == ISAB_ADDR || state == ISAB_CMD);
            clock_chip_addr_strobe <= state == ISAB_CMD && cur.valid &&
                cur.kind == ISAB_IOWR && io_is(cur, PORT_RTC_ADDR);
            clock_chip_rw_n <= !(state == ISAB_CMD && cur.valid &&
                cur.kind == ISAB_IOWR && io_is(cur, PORT_RTC_DATA));
            clock_chip_dstrobe_n <= !(state == ISAB_CMD && cur.valid &&
                cur.kind == ISAB_IORD && io_is(cur, PORT_RTC_DATA));
            rom_clockchip_sel_n <= !(cur.valid && state != ISAB_IDLE &&
                ((!cur.kind[1] && cur.addr >= ROM_BASE &&
                  cur.addr < ONE_MEG) ||
                 io_is(cur, PORT_RTC_ADDR) ||
                 io_is(cur, PORT_RTC_DATA)));
            keyboard_sel_n <= !(cur.valid && state != ISAB_IDLE &&
                (io_is(cur, PORT_KBD_A) || io_is(cur, PORT_KBD_B)));
            gp_latch_sel_n <= 1'b1;
        end
    end
endmodule

// *** isab_card.sv ***
module isab_card
    import isab_pkg::*;
(
    input wire logic clk,
    input isab_cmd_s cmd_out,
    input wire logic [3:0] slow,
    input wire logic fast,
    output logic iochrdy_in,
    output logic zws_n
);
    logic [3:0] cnt;
    logic act;
    assign act = !(cmd_out.memr_n & cmd_out.memw_n & cmd_out.ior_n
        & cmd_out.iow_n);
    always_ff @(posedge clk) begin
        cnt <= act ? cnt + 4'h1 : 4'h0;
    end
    // lines pulled up when card is idle
    assign iochrdy_in = !act || cnt >= slow;
    assign zws_n = !(act && fast);
endmodule

// *** isab_port_asserts.sv ***
module isab_port_asserts
    import isab_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic master_n,
    input wire logic chk_enable,
    input wire logic iochck_n,
    input wire logic [23:17] la_out,
    input wire logic la_oe,
    input wire logic sa_oe,
    input isab_cmd_s cmd_out,
    input wire logic cmd_oe,
    input wire logic ale,
    input wire logic nmi,
    input wire logic busy,
    input wire logic done,
    input wire logic xcvr_oe_n,
    input wire logic clock_chip_rw_n,
    input wire logic clock_chip_dstrobe_n,
    input wire logic [2:0] dma_ack_encoded_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_start;
        $rose(busy) && master_n;
    endsequence
    sequence s_finish;
        ##[2:60] done;
    endsequence
    property p_cycle;
        s_start |-> s_finish;
    endproperty
    a_reset_ale: assert property ($fell(rst) |-> !ale)
        else $error("ale high after reset");
    a_reset_dack: assert property ($fell(rst) |->
        dma_ack_encoded_out == DACK_IDLE)
        else $error("dack not idle after reset");
    a_master_sa: assert property (!master_n |=> !sa_oe)
        else $error("sa driven under master");
    a_master_la: assert property (!master_n |=> !la_oe)
        else $error("la driven under master");
    a_master_cmd: assert property (!master_n |=> !cmd_oe)
        else $error("commands driven under master");
    a_master_ale: assert property (!master_n |=> ale)
        else $error("ale low under master");
    a_low_smemw: assert property (cmd_oe && !cmd_out.smemw_n |->
        la_out[23:20] == 4'h0)
        else $error("smemw above one megabyte");
    a_ref_memr: assert property (cmd_oe && !cmd_out.ref_n |->
        !cmd_out.memr_n && !cmd_out.smemr_n)
        else $error("refresh without memr");
    a_nmi_raise: assert property (!iochck_n && chk_enable |->
        ##[1:3] nmi)
        else $error("nmi not raised");
    a_ds_xcvr: assert property (!clock_chip_dstrobe_n |-> !xcvr_oe_n)
        else $error("data strobe without xcvr");
    a_rw_xcvr: assert property (!clock_chip_rw_n |-> !xcvr_oe_n)
        else $error("rw without xcvr");
    a_cycle_done: assert property (p_cycle)
        else $error("cycle never ended");
endmodule
bind isab_port isab_port_asserts isab_port_asserts_inst (.clk, .rst,
    .master_n, .chk_enable, .iochck_n, .la_out, .la_oe, .sa_oe, .cmd_out,
    .cmd_oe, .ale, .nmi, .busy, .done, .xcvr_oe_n, .clock_chip_rw_n,
    .clock_chip_dstrobe_n, .dma_ack_encoded_out);

// *** isab_port_tb.sv ***
module isab_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import isab_pkg::*;
    logic clk, rst, pci_bus_clk, osc_ref, clk_src_osc, refresh_req;
    logic host_clk_tick, chk_enable, master_n, zws_n, iochrdy_in, fast;
    logic iochck_n, mcs16_n, slv_ready, la_oe, sa_oe, cmd_oe, ale, aen;
    logic [3:0] irq_muxed_in, slow, dma_req;
    logic [1:0] dma_req_muxed_in;
    logic [23:17] la_in, la_out;
    logic [19:0] sa_in, sa_out;
    isab_req_s req;
    isab_cmd_s cmd_in, cmd_out;
    logic expansion_clk, expansion_clk_double, osc_ref_out, iochrdy_out;
    logic iochrdy_oe, host_bus_hold, nmi, busy, done, word_ok, slv_hit, tc;
    logic xcvr_oe_n, clock_chip_addr_strobe, rom_clockchip_sel_n;
    logic keyboard_sel_n, clock_chip_rw_n, clock_chip_dstrobe_n;
    logic gp_latch_sel_n;
    logic [7:0] irq_demux;
    logic [2:0] dma_ack_encoded_out;
    int mismatches, total_checks;
    isab_port isab_port_inst (.clk, .rst, .pci_bus_clk, .osc_ref,
        .clk_src_osc, .req, .refresh_req, .host_clk_tick, .chk_enable,
        .master_n, .la_in, .sa_in, .cmd_in, .zws_n, .iochrdy_in, .iochck_n,
        .mcs16_n, .slv_ready, .irq_muxed_in, .dma_req_muxed_in,
        .expansion_clk, .expansion_clk_double, .osc_ref_out, .la_out, .la_oe,
        .sa_out, .sa_oe, .cmd_out, .cmd_oe, .ale, .aen, .iochrdy_out,
        .iochrdy_oe, .host_bus_hold, .nmi, .busy, .done, .word_ok, .slv_hit,
        .irq_demux, .dma_req, .dma_ack_encoded_out, .tc, .xcvr_oe_n,
        .clock_chip_addr_strobe, .rom_clockchip_sel_n, .keyboard_sel_n,
        .clock_chip_rw_n, .clock_chip_dstrobe_n, .gp_latch_sel_n);
    isab_card isab_card_inst (.clk, .cmd_out, .slow, .fast, .iochrdy_in,
        .zws_n);
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    always @(negedge clk) begin
        pci_bus_clk <= ~pci_bus_clk;
        osc_ref <= ~osc_ref;
        host_clk_tick <= ~host_clk_tick;
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic run(input isab_kind_e k, input logic [23:0] a,
            output int n, output logic [7:0] s);
        req = '0;
        req.valid = 1;
        req.kind = k;
        req.addr = a;
        s = '0;
        for (n = 1; n <= 80; n++) begin
            @(negedge clk);
            s |= {!cmd_out.smemr_n, !cmd_out.smemw_n,
                clock_chip_addr_strobe, !clock_chip_rw_n,
                !clock_chip_dstrobe_n, !rom_clockchip_sel_n, la_oe, ale};
            if (done === 1'b1) break;
        end
        req.valid = 0;
        if (n > 80) begin
            mismatches++;
            finish_test();
        end
        @(negedge clk);
    endtask
    task automatic t_clk(input logic osc, input int exp);
        int r = 0;
        int d = 0;
        logic p, q;
        clk_src_osc = osc;
        cyc(16);
        p = expansion_clk;
        q = expansion_clk_double;
        repeat (64) begin
            @(negedge clk);
            r += int'(expansion_clk && !p);
            d += int'(expansion_clk_double && !q);
            p = expansion_clk;
            q = expansion_clk_double;
        end
        chk(r, exp);
        chk(d, 2 * exp);
        $display("test clock source done");
    endtask
    task automatic t_cycles;
        isab_kind_e ks[7] = '{ISAB_MEMRD, ISAB_MEMWR, ISAB_MEMWR,
            ISAB_MEMRD, ISAB_IOWR, ISAB_IOWR, ISAB_IORD};
        logic [23:0] as[7] = '{24'h00_1234, 24'h20_0000, 24'h00_8000,
            24'h0F_8000, 24'h00_0070, 24'h00_0071, 24'h00_0071};
        logic [7:0] es[7] = '{8'h83, 8'h03, 8'h43, 8'h87, 8'h27, 8'h17,
            8'h0F};
        int n;
        logic [7:0] s;
        for (int i = 0; i < 7; i++) begin
            run(ks[i], as[i], n, s);
            chk(s, es[i]);
        end
        $display("test host cycles done");
    endtask
    task automatic t_ready;
        int n0, n1, n2;
        logic [7:0] s;
        run(ISAB_MEMRD, 24'h00_1000, n0, s);
        slow = 4'hC;
        run(ISAB_MEMRD, 24'h00_1000, n1, s);
        fast = 1;
        slow = 4'h0;
        run(ISAB_MEMRD, 24'h00_1000, n2, s);
        fast = 0;
        chk(n1 > n0, 1);
        chk(n2 < n0, 1);
        $display("test ready done");
    endtask
    task automatic t_master;
        master_n = 0;
        req.valid = 1;
        cyc(3);
        chk({sa_oe, la_oe, cmd_oe, ale, busy}, 5'b00011);
        req.valid = 0;
        master_n = 1;
        cyc(3);
        chk(sa_oe, 1);
        $display("test master done");
    endtask
    task automatic t_refresh;
        int h = 0;
        logic r = 0;
        refresh_req = 1;
        repeat (40) begin
            @(negedge clk);
            if (busy === 1'b1 || host_bus_hold === 1'b1) refresh_req = 0;
            h += int'(host_bus_hold && host_clk_tick);
            r |= cmd_oe && !cmd_out.ref_n && !cmd_out.memr_n
                && !cmd_out.smemr_n;
        end
        chk(h == 2 || h == 3, 1);
        chk(r, 1);
        $display("test refresh done");
    endtask
    task automatic t_nmi;
        iochck_n = 0;
        cyc(4);
        chk(nmi, 0);
        chk_enable = 1;
        cyc(4);
        chk(nmi, 1);
        iochck_n = 1;
        chk_enable = 0;
        cyc(4);
        $display("test nmi done");
    endtask
    task automatic t_irq;
        irq_muxed_in = 4'h0;
        dma_req_muxed_in = 2'h3;
        cyc(40);
        chk(irq_demux, 8'h80);
        chk(dma_req, 4'hF);
        irq_muxed_in = 4'hF;
        dma_req_muxed_in = 2'h0;
        cyc(40);
        chk(irq_demux, 8'h7F);
        chk(dma_req, 4'h0);
        chk(dma_ack_encoded_out, DACK_IDLE);
        $display("test irq done");
    endtask
    initial begin
        {pci_bus_clk, osc_ref, clk_src_osc, refresh_req, fast} = '0;
        {host_clk_tick, chk_enable, slow, dma_req_muxed_in} = '0;
        {master_n, iochck_n, mcs16_n, slv_ready} = 4'hF;
        irq_muxed_in = 4'h0;
        la_in = '0;
        sa_in = '0;
        req = '0;
        cmd_in = '1;
        mismatches = 0;
        total_checks = 0;
        rst = 1;
        cyc(4);
        rst = 0;
        chk(ale, 0);
        chk(rom_clockchip_sel_n, 1);
        t_clk(1, 16);
        t_clk(0, 8);
        t_cycles();
        t_ready();
        t_master();
        t_refresh();
        t_nmi();
        t_irq();
        finish_test();
    end
endmodule
